// [verilog/mdsf_top.sv]
// status flag word of a two-phase stepper driver, with the
// off-time setting, power stage enable and event interrupt
// assumes analog detector levels and the disable pin are
// asynchronous; step, load, scale and mode come from logic
// on the system clock
`timescale 1ns/10ps
module mdsf_top #(
	parameter int IDLE_CLOCKS = mdsf_pkg::IDLE_CLOCKS // standstill
) (
	input  wire logic        i_sys_clk,         // 100 MHz clock
	input  wire logic        i_rst_n,           // async reset, low
	input  wire logic [6:0]  i_addr,            // register index
	input  wire logic [31:0] i_wr_data,         // write data
	input  wire logic        i_wr,              // write strobe
	input  wire logic        i_rd,              // read strobe
	output logic      [31:0] o_rd_data,         // read data, +1
	output logic             o_irq,             // level interrupt
	output logic             o_driver_enable,   // power stage on
	output logic      [3:0]  o_chopper_off_time,// off-time value
	input  wire logic        i_step_pulse,      // step strobe
	input  wire logic        i_open_load_a,     // async detector
	input  wire logic        i_open_load_b,     // async detector
	input  wire logic        i_ground_short_a,  // async detector
	input  wire logic        i_ground_short_b,  // async detector
	input  wire logic        i_thermal_prewarn, // async detector
	input  wire logic        i_thermal_limit,   // async detector
	input  wire logic        i_driver_disable_input, // pin
	input  wire logic [9:0]  i_load_measure_value, // load value
	input  wire logic        i_load_speed_mode, // load speed on
	input  wire logic        i_load_speed_stall,// stall there
	input  wire logic [4:0]  i_current_scale,   // actual scale
	input  wire logic        i_fullstep_active  // full-step on
);
	// ************************************************
	// input synchronisers
	// ************************************************
	localparam int SY_W = 7; // number of async levels
	logic [SY_W-1:0] sy1_q;  // first stage, read by sy2 only
	logic [SY_W-1:0] sy2_q;  // second stage, safe to use
	logic [SY_W-1:0] sy_raw; // raw async bundle
	logic [SY_W-1:0] sy1_d;  // next first stage
	logic [SY_W-1:0] sy2_d;  // next second stage
	// bundle the detector levels and the disable pin
	always_comb begin
		sy_raw = {i_driver_disable_input, i_thermal_limit,
			i_thermal_prewarn, i_ground_short_b,
			i_ground_short_a, i_open_load_b, i_open_load_a};
		sy1_d  = sy_raw;
		sy2_d  = sy1_q;
	end
	// two flops against metastability
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sy1_q <= '0;
			sy2_q <= '0;
		end else begin
			sy1_q <= sy1_d;
			sy2_q <= sy2_d;
		end
	end
	logic       ol_a_s;  // open load a, synced
	logic       ol_b_s;  // open load b, synced
	logic [1:0] gs_s;    // ground shorts {b,a}, synced
	logic       pw_s;    // pre-warning, synced
	logic       lim_s;   // thermal limit, synced
	logic       dis_s;   // disable pin, synced
	assign ol_a_s = sy2_q[0];
	assign ol_b_s = sy2_q[1];
	assign gs_s   = sy2_q[3:2];
	assign pw_s   = sy2_q[4];
	assign lim_s  = sy2_q[5];
	assign dis_s  = sy2_q[6];

	// ************************************************
	// register port: off-time and mask
	// ************************************************
	logic [3:0] off_time_q; // chopper off-time
	logic [3:0] off_time_d;
	logic [7:0] mask_q;     // interrupt mask
	logic [7:0] mask_d;
	// writes to the status word fall through untouched
	always_comb begin
		off_time_d = off_time_q;
		mask_d     = mask_q;
		if (i_wr && i_addr == mdsf_pkg::ADDR_OFF_TIME) begin
			off_time_d = i_wr_data[mdsf_pkg::OFF_TIME_W-1:0];
		end
		if (i_wr && i_addr == mdsf_pkg::ADDR_IRQ_MK) begin
			mask_d = i_wr_data[mdsf_pkg::EVT_W-1:0];
		end
	end
	// register only
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			off_time_q <= mdsf_pkg::OFF_TIME_RST;
			mask_q     <= mdsf_pkg::MASK_RST;
		end else begin
			off_time_q <= off_time_d;
			mask_q <= mask_d;
		end
	end

	// ************************************************
	// standstill timer
	// ************************************************
	mdsf_idle_if idle_bus (); // step/idle pair
	assign idle_bus.step = i_step_pulse;
	mdsf_idle_timer #(
		.IDLE_CLOCKS (IDLE_CLOCKS)
	) u_idle (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.bus       (idle_bus.timer)
	);

	// ************************************************
	// ground short latches
	// ************************************************
	logic       drv_off;  // host has switched driver off
	logic [1:0] gs_clr;   // clear both latches
	logic [1:0] gs_flag;  // latched shorts {b,a}
	// either software off-time zero or the pin releases them
	assign drv_off = (off_time_q == '0) || dis_s;
	assign gs_clr  = {2{drv_off}};
	mdsf_sticky #(
		.W (2)
	) u_gshort (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_set     (gs_s),
		.i_clr     (gs_clr),
		.o_flag    (gs_flag)
	);

	// ************************************************
	// thermal protection
	// ************************************************
	mdsf_pkg::mdsf_therm_t th_q; // thermal state
	mdsf_pkg::mdsf_therm_t th_d;
	// hot state only ends once the pre-warning is also gone
	always_comb begin
		case (th_q)
			mdsf_pkg::MDSF_TH_RUN: begin
				th_d = lim_s ? mdsf_pkg::MDSF_TH_HOT
					: mdsf_pkg::MDSF_TH_RUN;
			end
			mdsf_pkg::MDSF_TH_HOT: begin
				th_d = (!lim_s && !pw_s) ? mdsf_pkg::MDSF_TH_RUN
					: mdsf_pkg::MDSF_TH_HOT;
			end
			default: begin
				th_d = mdsf_pkg::MDSF_TH_HOT; // fail safe
			end
		endcase
	end
	// register only
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			th_q <= mdsf_pkg::MDSF_TH_RUN;
		end else begin
			th_q <= th_d;
		end
	end
	logic hot; // thermal shutdown active
	assign hot = (th_q != mdsf_pkg::MDSF_TH_RUN);

	// ************************************************
	// status word and power stage enable
	// ************************************************
	logic [31:0] st_q; // driver_status_flags
	logic [31:0] st_d;
	logic        en_d; // next driver enable
	logic        en_q;
	logic        stall; // stall indication
	// zero load is the heaviest load, so it means stall
	assign stall = (i_load_measure_value == '0) ||
		(i_load_speed_mode && i_load_speed_stall);
	// open load feeds the word only, never the enable
	always_comb begin
		st_d = '0; // reserved and omitted bits stay zero
		st_d[mdsf_pkg::BIT_IDLE]     = idle_bus.idle;
		st_d[mdsf_pkg::BIT_OPEN_B]   = ol_b_s;
		st_d[mdsf_pkg::BIT_OPEN_A]   = ol_a_s;
		st_d[mdsf_pkg::BIT_GSHORT_B] = gs_flag[1];
		st_d[mdsf_pkg::BIT_GSHORT_A] = gs_flag[0];
		st_d[mdsf_pkg::BIT_PREWARN]  = pw_s;
		st_d[mdsf_pkg::BIT_THERMAL]  = hot;
		st_d[mdsf_pkg::BIT_STALL]    = stall;
		st_d[mdsf_pkg::CS_LSB +: mdsf_pkg::CS_W] =
			i_current_scale;
		st_d[mdsf_pkg::BIT_FULLSTEP] = i_fullstep_active;
		// raw short also blocks, saving a cycle of exposure
		en_d = !drv_off && !(|gs_flag) && !(|gs_s)
			&& !hot && !lim_s;
	end
	// register only
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q <= '0;
			en_q <= 1'b0;
		end else begin
			st_q <= st_d;
			en_q <= en_d;
		end
	end

	// ************************************************
	// interrupt events
	// ************************************************
	logic [7:0] ev;     // rising edges of flags 31..24
	logic [7:0] ev_clr; // read clears all
	logic [7:0] ev_st;  // sticky event status
	logic       irq_d;
	logic       irq_q;
	assign ev = st_d[mdsf_pkg::EVT_LSB +: mdsf_pkg::EVT_W]
		& ~st_q[mdsf_pkg::EVT_LSB +: mdsf_pkg::EVT_W];
	assign ev_clr = {8{i_rd && i_addr == mdsf_pkg::ADDR_IRQ_ST}};
	mdsf_sticky #(
		.W (8)
	) u_events (
		.i_sys_clk (i_sys_clk),
		.i_rst_n   (i_rst_n),
		.i_set     (ev),
		.i_clr     (ev_clr),
		.o_flag    (ev_st)
	);
	// level output, follows the gated sticky bits
	always_comb begin
		irq_d = |(ev_st & mask_q);
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// ************************************************
	// read path
	// ************************************************
	logic [31:0] rd_d; // next read data
	logic [31:0] rd_q;
	// data only in the cycle after the strobe, else zero
	always_comb begin
		rd_d = '0;
		if (i_rd) begin
			case (i_addr)
				mdsf_pkg::ADDR_STATUS: rd_d = st_q;
				mdsf_pkg::ADDR_OFF_TIME: rd_d = {28'h0, off_time_q};
				mdsf_pkg::ADDR_IRQ_ST: rd_d = {24'h0, ev_st};
				mdsf_pkg::ADDR_IRQ_MK: rd_d = {24'h0, mask_q};
				default:               rd_d = '0; // unmapped
			endcase
		end
	end
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rd_q <= '0;
		end else begin
			rd_q <= rd_d;
		end
	end
	assign o_rd_data          = rd_q;
	assign o_irq              = irq_q;
	assign o_driver_enable    = en_q;
	assign o_chopper_off_time = off_time_q;

	// ************************************************
	// assertions
	// ************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	chk_step_clears_idle: assert property (
		i_step_pulse |=> ##1 !st_q[mdsf_pkg::BIT_IDLE])
		else $error("idle flag set right after step");
	chk_open_load_word: assert property (
		st_q[mdsf_pkg::BIT_OPEN_B] == $past(ol_b_s) &&
		st_q[mdsf_pkg::BIT_OPEN_A] == $past(ol_a_s))
		else $error("open load bits do not follow detector");
	chk_short_disables: assert property (
		(|gs_s) |=> !o_driver_enable ##1 st_q[28:27] != 2'b00
		|| drv_off)
		else $error("ground short did not disable driver");
	chk_short_held: assert property (
		(|gs_flag) && !drv_off |=> (|gs_flag) && !o_driver_enable)
		else $error("short flag dropped while driver on");
	chk_short_release: assert property (
		drv_off && !(|gs_s) |=> gs_flag == 2'b00)
		else $error("short flag kept after driver off");
	chk_prewarn_bit: assert property (
		$rose(pw_s) |=> st_q[mdsf_pkg::BIT_PREWARN])
		else $error("pre-warning bit missing");
	chk_thermal_hold: assert property (
		hot && pw_s |=> hot ##1 st_q[mdsf_pkg::BIT_THERMAL])
		else $error("thermal shutdown left while still warm");
	chk_thermal_enable: assert property (
		hot |=> !o_driver_enable)
		else $error("driver on during thermal shutdown");
	chk_stall_zero: assert property (
		i_load_measure_value == '0 |=> st_q[mdsf_pkg::BIT_STALL])
		else $error("stall bit missing at zero load");
	chk_scale_field: assert property (
		st_q[20:16] == $past(i_current_scale))
		else $error("current scale field wrong");
	chk_fullstep_bit: assert property (
		st_q[mdsf_pkg::BIT_FULLSTEP] == $past(i_fullstep_active))
		else $error("full-step bit wrong");
	chk_status_reserved: assert property (
		i_rd && i_addr == mdsf_pkg::ADDR_STATUS
		|=> o_rd_data[23:21] == 3'h0 && o_rd_data[14:0] == 15'h0)
		else $error("reserved status bits not zero");
	chk_irq_level: assert property (
		(|(ev_st & mask_q)) |=> o_irq)
		else $error("interrupt not raised");

	cov_short_event: cover property ((|gs_s) ##1 (|gs_flag));
	cov_thermal_cycle: cover property ($rose(hot) ##[1:50] $fell(hot));
	cov_irq_read: cover property (o_irq ##[1:20] ev_clr[0]);
	cov_status_read: cover property (
		i_rd && i_addr == mdsf_pkg::ADDR_STATUS);
endmodule : mdsf_top

// [common/mdsf_pkg.sv]
// constants for the motor driver status flag block
// assumes one 100 MHz clock and a plain strobe register port
package mdsf_pkg;
	// ************************************************
	// register map (word indices on the plain port)
	// ************************************************
	localparam int         ADDR_W      = 7;
	localparam logic [6:0] ADDR_OFF_TIME = 7'h6C; // off-time setting
	localparam logic [6:0] ADDR_STATUS = 7'h6F; // status word
	localparam logic [6:0] ADDR_IRQ_ST = 7'h70; // sticky events
	localparam logic [6:0] ADDR_IRQ_MK = 7'h71; // event mask
	// ************************************************
	// status word fields
	// ************************************************
	localparam int BIT_IDLE     = 31;
	localparam int BIT_OPEN_B   = 30;
	localparam int BIT_OPEN_A   = 29;
	localparam int BIT_GSHORT_B = 28;
	localparam int BIT_GSHORT_A = 27;
	localparam int BIT_PREWARN  = 26;
	localparam int BIT_THERMAL  = 25;
	localparam int BIT_STALL    = 24;
	localparam int CS_LSB       = 16;
	localparam int CS_W         = 5;
	localparam int BIT_FULLSTEP = 15;
	localparam int EVT_LSB      = 24; // events mirror bits 31..24
	localparam int EVT_W        = 8;
	// ************************************************
	// widths, reset values, timing
	// ************************************************
	localparam int          OFF_TIME_W   = 4;
	localparam int          LOAD_W       = 10;
	localparam logic [3:0]  OFF_TIME_RST = 4'h0;
	localparam logic [7:0]  MASK_RST   = 8'h00;
	localparam int          IDLE_CLOCKS = 1048576; // 2^20 clocks
	// thermal protection states, one-hot
	typedef enum logic [1:0] {
		MDSF_TH_RUN  = 2'b01,
		MDSF_TH_HOT  = 2'b10
	} mdsf_therm_t;
endpackage : mdsf_pkg

// [common/mdsf_idle_if.sv]
// step pulse and idle indication between top and idle timer
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface mdsf_idle_if;
	logic step; // one-cycle step pulse
	logic idle; // standstill reached
	modport timer (input step, output idle);
	modport user  (output step, input idle);
endinterface : mdsf_idle_if

// [verilog/mdsf_sticky.sv]
// vector of sticky flags, set dominates clear
// assumes set and clear come from the system clock domain
`timescale 1ns/10ps
module mdsf_sticky #(
	parameter int W = 1 // number of flags
) (
	input  wire logic         i_sys_clk, // system clock
	input  wire logic         i_rst_n,   // async reset, low
	input  wire logic [W-1:0] i_set,     // set requests
	input  wire logic [W-1:0] i_clr,     // clear requests
	output logic      [W-1:0] o_flag     // held flags
);
	logic [W-1:0] flag_q; // flag storage
	logic [W-1:0] flag_d; // next flag value
	// a set in the clear cycle must not be lost
	always_comb begin
		flag_d = (flag_q & ~i_clr) | i_set;
	end
	// register only
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end
	assign o_flag = flag_q;
endmodule : mdsf_sticky

// [verilog/mdsf_idle_timer.sv]
// standstill timer: counts clocks since the last step pulse
// assumes step pulses are synchronous one-cycle strobes
`timescale 1ns/10ps
module mdsf_idle_timer #(
	parameter int IDLE_CLOCKS = mdsf_pkg::IDLE_CLOCKS // to standstill
) (
	input  wire logic i_sys_clk, // system clock
	input  wire logic i_rst_n,   // async reset, low
	mdsf_idle_if.timer bus       // step in, idle out
);
	localparam int CNT_W = $clog2(IDLE_CLOCKS + 1);
	localparam logic [CNT_W-1:0] CNT_END = CNT_W'(IDLE_CLOCKS);
	logic [CNT_W-1:0] cnt_q; // clocks since last step
	logic [CNT_W-1:0] cnt_d; // next count
	// saturate so the flag stays up during long standstill
	always_comb begin
		if (bus.step) begin
			cnt_d = '0;
		end else if (cnt_q == CNT_END) begin
			cnt_d = cnt_q;
		end else begin
			cnt_d = cnt_q + CNT_W'(1);
		end
	end
	// register only
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	assign bus.idle = (cnt_q == CNT_END);
endmodule : mdsf_idle_timer

// [bench/test_motor_driver_status_flags.sv]
// self-checking bench for the motor driver status flag block
// assumes mdsf_pkg and the design files are compiled before it
`timescale 1ns/10ps
module test_motor_driver_status_flags;
	// ************************************************
	// signals
	// ************************************************
	localparam int IDLE_N = 16;    // short standstill count for speed
	localparam int LIMIT  = 20000; // hang ceiling in clocks
	logic        clk     = 1'b0;   // system clock
	logic        rst_n   = 1'b0;   // reset, low
	logic [6:0]  addr    = 7'h00;  // register index
	logic [31:0] wdat    = 32'h0;  // write data
	logic        wr      = 1'b0;   // write strobe
	logic        rd      = 1'b0;   // read strobe
	logic [31:0] rdat;             // read data
	logic        irq;              // interrupt
	logic        drv_en;           // power stage on
	logic [3:0]  off_time_o;       // off-time shown
	logic        step    = 1'b0;   // step strobe
	logic        ol_a    = 1'b0;   // open load a
	logic        ol_b    = 1'b0;   // open load b
	logic        gs_a    = 1'b0;   // ground short a
	logic        gs_b    = 1'b0;   // ground short b
	logic        prew    = 1'b0;   // thermal pre-warning
	logic        tlim    = 1'b0;   // thermal limit
	logic        pin     = 1'b0;   // disable pin
	logic [9:0]  load    = 10'h3FF; // load value, light load
	logic        lmode   = 1'b0;   // load speed mode
	logic        lstall  = 1'b0;   // stall in that mode
	logic [4:0]  cs      = 5'h00;  // current scale
	logic        fs      = 1'b0;   // full step
	logic        gsa_l   = 1'b0;   // expected latch a
	logic        gsb_l   = 1'b0;   // expected latch b
	logic        th_l    = 1'b0;   // expected shutdown
	logic [3:0]  tv      = 4'h0;   // expected off-time
	logic [31:0] rv;               // last read word
	int          error_cnt = 0;    // mismatches
	int          cmp_count = 0;    // comparisons
	int          cyc       = 0;    // clock count

	always #5 clk = ~clk;

	mdsf_top #(.IDLE_CLOCKS(IDLE_N)) i_dut (
		.i_sys_clk(clk), .i_rst_n(rst_n), .i_addr(addr),
		.i_wr_data(wdat), .i_wr(wr), .i_rd(rd), .o_rd_data(rdat),
		.o_irq(irq), .o_driver_enable(drv_en),
		.o_chopper_off_time(off_time_o), .i_step_pulse(step),
		.i_open_load_a(ol_a), .i_open_load_b(ol_b),
		.i_ground_short_a(gs_a), .i_ground_short_b(gs_b),
		.i_thermal_prewarn(prew), .i_thermal_limit(tlim),
		.i_driver_disable_input(pin), .i_load_measure_value(load),
		.i_load_speed_mode(lmode), .i_load_speed_stall(lstall),
		.i_current_scale(cs), .i_fullstep_active(fs)
	);

	// ************************************************
	// helpers
	// ************************************************
	// expected status word from what the bench drives
	function automatic logic [31:0] stat(input logic idle);
		stat = {idle, ol_b, ol_a, gsb_l, gsa_l, prew, th_l,
			(load == 10'h000) | (lmode & lstall), 3'h0, cs, fs,
			15'h0000};
	endfunction : stat

	// expected power stage enable
	function automatic logic en_exp();
		en_exp = (tv != 4'h0) & ~pin & ~gsa_l & ~gsb_l & ~gs_a
			& ~gs_b & ~th_l & ~tlim;
	endfunction : en_exp

	task automatic end_sim();
		$display("counts: %0d compares, %0d errors", cmp_count,
			error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_sim

	task automatic cmp32(input logic [31:0] e, g, input string m);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t %s exp %h got %h", $time, m, e, g);
		end
	endtask : cmp32

	task automatic cmp1(input logic e, g, input string m);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %0t %s exp %b got %b", $time, m, e, g);
		end
	endtask : cmp1

	// enable and interrupt are looked at mid-cycle, away from the
	// edge that launches them, then the bench is back on the edge
	task automatic cmp_en(input logic e, input string m);
		@(negedge clk);
		cmp1(e, drv_en, m);
		@(posedge clk);
	endtask : cmp_en

	task automatic cmp_irq(input logic e, input string m);
		@(negedge clk);
		cmp1(e, irq, m);
		@(posedge clk);
	endtask : cmp_irq

	// one-cycle write strobe
	task automatic wr_reg(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		wr   <= 1'b1;
		@(posedge clk);
		wr   <= 1'b0;
	endtask : wr_reg

	// one-cycle read strobe, data taken in the following cycle
	task automatic rd_reg(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		@(negedge clk);
		d = rdat;
	endtask : rd_reg

	// detector levels pass two flops plus the word register
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask : settle

	task automatic chk_stat(input string m);
		rd_reg(mdsf_pkg::ADDR_STATUS, rv);
		cmp32(stat(1'b1), rv, m);
	endtask : chk_stat

	// ************************************************
	// scenarios
	// ************************************************
	task automatic t_reset();
		rd_reg(mdsf_pkg::ADDR_OFF_TIME, rv);
		cmp32(32'h0, rv, "off-time reset");
		cmp32(32'h0, {28'h0, off_time_o}, "off-time pin reset");
		rd_reg(mdsf_pkg::ADDR_IRQ_MK, rv);
		cmp32(32'h0, rv, "mask reset");
		cmp1(1'b0, drv_en, "enable at reset");
		chk_stat("status at reset");
		cmp1(1'b0, irq, "irq at reset");
		$display("test reset done");
	endtask : t_reset

	task automatic t_idle();
		@(posedge clk);
		step <= 1'b1;
		@(posedge clk);
		step <= 1'b0;
		// last read before the flag, then the first read with it
		repeat (IDLE_N - 1) @(posedge clk);
		rd_reg(mdsf_pkg::ADDR_STATUS, rv);
		cmp1(1'b0, rv[31], "idle too early");
		rd_reg(mdsf_pkg::ADDR_STATUS, rv);
		cmp1(1'b1, rv[31], "idle missing");
		$display("test idle done");
	endtask : t_idle

	task automatic t_open();
		wr_reg(mdsf_pkg::ADDR_OFF_TIME, 32'h5);
		tv = 4'h5;
		settle();
		cmp_en(1'b1, "enable on");
		ol_a <= 1'b1;
		ol_b <= 1'b1;
		settle();
		chk_stat("open load");
		cmp32(32'h5, {28'h0, off_time_o}, "off-time pin");
		cmp_en(1'b1, "open load no action");
		@(posedge clk);
		ol_a <= 1'b0;
		ol_b <= 1'b0;
		$display("test open load done");
	endtask : t_open

	task automatic t_short();
		gs_a <= 1'b1;
		gsa_l = 1'b1;
		settle();
		chk_stat("short a");
		cmp_en(1'b0, "short a enable");
		gs_a <= 1'b0;
		settle();
		chk_stat("short a held");
		cmp_en(1'b0, "held enable");
		wr_reg(mdsf_pkg::ADDR_OFF_TIME, 32'h0);
		tv = 4'h0;
		gsa_l = 1'b0;
		settle();
		chk_stat("short a cleared");
		wr_reg(mdsf_pkg::ADDR_OFF_TIME, 32'h5);
		tv = 4'h5;
		gs_b <= 1'b1;
		gsb_l = 1'b1;
		settle();
		chk_stat("short b");
		cmp_en(en_exp(), "short b enable");
		gs_b <= 1'b0;
		pin  <= 1'b1;
		gsb_l = 1'b0;
		settle();
		chk_stat("short b cleared by pin");
		cmp_en(1'b0, "pin disables");
		@(posedge clk);
		pin <= 1'b0;
		settle();
		cmp_en(1'b1, "enable back");
		$display("test short done");
	endtask : t_short

	task automatic t_therm();
		prew <= 1'b1;
		settle();
		chk_stat("prewarn");
		@(posedge clk);
		tlim <= 1'b1;
		th_l = 1'b1;
		settle();
		chk_stat("thermal limit");
		cmp_en(1'b0, "hot enable");
		tlim <= 1'b0;
		settle();
		chk_stat("held while prewarn");
		cmp_en(1'b0, "still hot");
		prew <= 1'b0;
		th_l = 1'b0;
		settle();
		chk_stat("cooled");
		cmp_en(1'b1, "cooled enable");
		$display("test thermal done");
	endtask : t_therm

	task automatic t_stall();
		load <= 10'h000;
		settle();
		chk_stat("zero load stall");
		@(posedge clk);
		load   <= 10'h155;
		lmode  <= 1'b1;
		lstall <= 1'b1;
		settle();
		chk_stat("speed mode stall");
		@(posedge clk);
		lmode <= 1'b0;
		settle();
		chk_stat("stall outside mode");
		$display("test stall done");
	endtask : t_stall

	task automatic t_scale();
		@(posedge clk);
		cs <= 5'h15;
		fs <= 1'b1;
		settle();
		chk_stat("scale and full step");
		@(posedge clk);
		cs <= 5'h0A;
		fs <= 1'b0;
		settle();
		chk_stat("scale change");
		wr_reg(mdsf_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		chk_stat("write ignored");
		rd_reg(7'h05, rv);
		cmp32(32'h0, rv, "unmapped read");
		$display("test scale done");
	endtask : t_scale

	task automatic t_irq();
		rd_reg(mdsf_pkg::ADDR_IRQ_ST, rv);
		wr_reg(mdsf_pkg::ADDR_IRQ_MK, 32'h04);
		ol_a <= 1'b1;
		settle();
		cmp_irq(1'b0, "masked event");
		prew <= 1'b1;
		settle();
		cmp_irq(1'b1, "unmasked event");
		rd_reg(mdsf_pkg::ADDR_IRQ_ST, rv);
		cmp32(32'h24, rv, "event status");
		repeat (2) @(posedge clk);
		cmp_irq(1'b0, "irq cleared");
		ol_a <= 1'b0;
		prew <= 1'b0;
		settle();
		$display("test interrupt done");
	endtask : t_irq

	// ************************************************
	// main sequence and hang guard
	// ************************************************
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			$display("[ERR] %0t timeout", $time);
			end_sim();
		end
	end

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (IDLE_N + 4) @(posedge clk);
		t_reset();
		t_idle();
		t_open();
		t_short();
		t_therm();
		t_stall();
		t_scale();
		t_irq();
		end_sim();
	end
endmodule : test_motor_driver_status_flags
